// [core/link_pulse_pkg.sv]
package link_pulse_pkg;

    localparam int CLK_PERIOD_NS      = 10;

    localparam int PULSE_WIDTH_NS     = 100;
    localparam int PULSE_WIDTH_CYC    = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int IDLE_PERIOD_MS      = 16;
    localparam int IDLE_PERIOD_MIN_MS  = 8;
    localparam int IDLE_PERIOD_MAX_MS  = 24;
    localparam int IDLE_PERIOD_CYC     = IDLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int IDLE_MIN_CYC        = (IDLE_PERIOD_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    localparam int IDLE_MAX_CYC        = IDLE_PERIOD_MAX_MS * 1000000 / CLK_PERIOD_NS;

    localparam int CLK_INTERVAL_NS     = 125000;
    localparam int CLK_INTERVAL_MIN_NS = 111000;
    localparam int CLK_INTERVAL_MAX_NS = 139000;
    localparam int CLK_INTERVAL_CYC    = CLK_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int CLK_INT_MIN_CYC     = (CLK_INTERVAL_MIN_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    localparam int CLK_INT_MAX_CYC     = CLK_INTERVAL_MAX_NS / CLK_PERIOD_NS;

    localparam int DATA_OFFSET_NS      = 62500;
    localparam int DATA_OFFSET_MIN_NS  = 55500;
    localparam int DATA_OFFSET_MAX_NS  = 69500;
    localparam int DATA_OFFSET_CYC     = DATA_OFFSET_NS / CLK_PERIOD_NS;
    localparam int DATA_MIN_CYC        = (DATA_OFFSET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_MAX_CYC        = DATA_OFFSET_MAX_NS / CLK_PERIOD_NS;

    localparam int PAGE_BITS           = 16;
    localparam int BURST_PULSES_MIN    = 17;
    localparam int BURST_PULSES_MAX    = 33;
    localparam int BURST_WIDTH_MS     = 2;

    localparam int BURST_PERIOD_MS    = 16;
    localparam int BURST_MIN_MS       = 8;
    localparam int BURST_MAX_MS       = 24;
    localparam int BURST_PERIOD_CYC   = BURST_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BURST_MIN_CYC      = (BURST_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
    localparam int BURST_MAX_CYC      = BURST_MAX_MS * 1000000 / CLK_PERIOD_NS;

    localparam int DETECT_ON_MAX_US   = 1000;
    localparam int DETECT_OFF_MAX_US  = 300;
    localparam int DETECT_ON_CYC      = DETECT_ON_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int DETECT_OFF_CYC     = DETECT_OFF_MAX_US * 1000 / CLK_PERIOD_NS;

    localparam int CNT_W              = 22;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_IDLE = 3'b010,
        ST_NEG  = 3'b100
    } tx_state_t;

endpackage

// [core/signal_detect_qualifier.sv]
`timescale 1ns/100ps
module signal_detect_qualifier #(
    parameter int ON_CYC  = link_pulse_pkg::DETECT_ON_CYC,
    parameter int OFF_CYC = link_pulse_pkg::DETECT_OFF_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_raw,
    output logic      o_present
);
    import link_pulse_pkg::*;

    localparam logic [CNT_W-1:0] ON_LAST  = CNT_W'(ON_CYC - 1);
    localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYC - 1);

    logic [CNT_W-1:0] run_q;
    logic [CNT_W-1:0] run_d;
    logic             present_q;
    logic             present_d;

    // a short glitch restarts the count, so noise shorter than ON_CYC or OFF_CYC cycles never toggles the flag
    wire              differs  = i_raw != present_q;
    wire [CNT_W-1:0]  run_last = present_q ? OFF_LAST : ON_LAST;
    wire              expire   = differs && (run_q == run_last);

    assign run_d     = (!differs || expire) ? '0 : run_q + 1'b1;
    assign present_d = expire ? i_raw : present_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            run_q     <= '0;
            present_q <= 1'b0;
        end else begin
            run_q     <= run_d;
            present_q <= present_d;
        end
    end

    assign o_present = present_q;

    detect_turn_on_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (!present_q && differs) |-> (run_q <= ON_LAST))
        else $error("signal present late on turn-on");

    detect_turn_off_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $fell(present_q) |-> $past(run_q) == OFF_LAST && !$past(i_raw))
        else $error("signal present dropped at wrong time");

endmodule

// [core/link_pulse_timing_generator.sv]
`timescale 1ns/100ps
// Function
// - idle 10 Mb/s link pulses are 100 ns wide
// - idle link pulses repeat every 16 ms, within 8 to 24 ms
// - burst clock and data pulses are 100 ns wide
// - burst clock pulses are 125 us apart, within 111 to 139 us
// - a one puts a data pulse 55.5 to 69.5 us after its clock
// - a burst holds 17 to 33 pulses, clocks and data together
// - a burst spans 2 ms from first to last pulse
// - burst starts are 8 to 24 ms apart
// - signal present asserts within 1 ms of valid receive signal
// - signal present deasserts within 300 us of signal loss
module link_pulse_timing_generator #(
    parameter int IDLE_CYC     = link_pulse_pkg::IDLE_PERIOD_CYC,
    parameter int BURST_CYC    = link_pulse_pkg::BURST_PERIOD_CYC,
    parameter int INTERVAL_CYC = link_pulse_pkg::CLK_INTERVAL_CYC,
    parameter int DATA_CYC     = link_pulse_pkg::DATA_OFFSET_CYC,
    parameter int DETECT_ON    = link_pulse_pkg::DETECT_ON_CYC,
    parameter int DETECT_OFF   = link_pulse_pkg::DETECT_OFF_CYC
) (
    input  wire logic                                 i_clk,
    input  wire logic                                 i_resetn,
    input  wire logic                                 i_autoneg_en,
    input  wire logic                                 i_link_idle,
    input  wire logic [link_pulse_pkg::PAGE_BITS-1:0] i_page_word,
    input  wire logic                                 i_rx_energy,
    output logic                                      o_link_pulse,
    output logic                                      o_burst_active,
    output logic                                      o_burst_done,
    output logic                                      o_signal_present_detect
);
    import link_pulse_pkg::*;

    localparam logic [CNT_W-1:0] IDLE_LAST  = CNT_W'(IDLE_CYC - 1);
    localparam logic [CNT_W-1:0] BURST_LAST = CNT_W'(BURST_CYC - 1);
    localparam logic [CNT_W-1:0] SLOT_LAST  = CNT_W'(INTERVAL_CYC - 1);
    localparam logic [CNT_W-1:0] DATA_AT    = CNT_W'(DATA_CYC);
    localparam logic [7:0]       PW_LOAD    = 8'(PULSE_WIDTH_CYC);
    localparam logic [4:0]       BITS_END   = 5'(PAGE_BITS);

    // bounds scale with the configured nominal, so shortened counts still check
    localparam int IDLE_LO  = (IDLE_CYC * IDLE_PERIOD_MIN_MS + IDLE_PERIOD_MS - 1)
                              / IDLE_PERIOD_MS;
    localparam int IDLE_HI  = IDLE_CYC * IDLE_PERIOD_MAX_MS / IDLE_PERIOD_MS;
    localparam int BURST_LO = (BURST_CYC * BURST_MIN_MS + BURST_PERIOD_MS - 1)
                              / BURST_PERIOD_MS;
    localparam int BURST_HI = BURST_CYC * BURST_MAX_MS / BURST_PERIOD_MS;
    localparam int SLOT_LO  = (INTERVAL_CYC * CLK_INTERVAL_MIN_NS + CLK_INTERVAL_NS - 1)
                              / CLK_INTERVAL_NS;
    localparam int SLOT_HI  = INTERVAL_CYC * CLK_INTERVAL_MAX_NS / CLK_INTERVAL_NS;
    localparam int DATA_LO  = (DATA_CYC * DATA_OFFSET_MIN_NS + DATA_OFFSET_NS - 1)
                              / DATA_OFFSET_NS;
    localparam int DATA_HI  = DATA_CYC * DATA_OFFSET_MAX_NS / DATA_OFFSET_NS;

    tx_state_t                state_q;
    tx_state_t                state_d;
    logic [CNT_W-1:0]         per_q;
    logic [CNT_W-1:0]         per_d;
    logic [CNT_W-1:0]         per_last;
    logic [CNT_W-1:0]         slot_q;
    logic [CNT_W-1:0]         slot_d;
    logic [4:0]               bit_q;
    logic [4:0]               bit_d;
    logic                     burst_q;
    logic                     burst_d;
    logic [PAGE_BITS-1:0]     page_q;
    logic [PAGE_BITS-1:0]     page_d;
    logic [7:0]               pw_q;
    logic [7:0]               pw_d;
    logic                     pulse_q;
    logic                     done_q;

    // negotiation outranks idle pulses; idle pulses stop while data flows, bursts run whenever i_autoneg_en is high
    wire want_neg  = i_autoneg_en;
    wire want_idle = !i_autoneg_en && i_link_idle;
    assign state_d = want_neg ? ST_NEG : (want_idle ? ST_IDLE : ST_OFF);

    always_comb begin
        case (state_q)
            ST_IDLE: per_last = IDLE_LAST;
            ST_NEG:  per_last = BURST_LAST;
            default: per_last = '0;
        endcase
    end

    // the period counter is not restarted between idle and negotiation
    // modes, so the spacing holds across a mode change
    wire active       = state_q != ST_OFF;
    wire period_start = active && (per_q == '0);
    assign per_d = (!active || per_q == per_last) ? '0 : per_q + 1'b1;

    wire idle_fire   = (state_q == ST_IDLE) && period_start;
    wire burst_start = (state_q == ST_NEG) && period_start && !burst_q;
    wire slot_last   = slot_q == SLOT_LAST;
    wire clk_fire    = burst_q && (slot_q == '0);
    wire bit_one     = page_q[bit_q[3:0]];
    wire data_fire   = burst_q && (slot_q == DATA_AT) && (bit_q != BITS_END) && bit_one;
    wire last_clk    = clk_fire && (bit_q == BITS_END);
    wire fire        = idle_fire || clk_fire || data_fire;

    assign burst_d = (state_q != ST_NEG) ? 1'b0 :
                     burst_start ? 1'b1 :
                     last_clk    ? 1'b0 : burst_q;
    assign slot_d  = (!burst_q || slot_last || last_clk) ? '0 : slot_q + 1'b1;
    assign bit_d   = (!burst_q || last_clk) ? '0 : (slot_last ? bit_q + 1'b1 : bit_q);
    assign page_d  = burst_start ? i_page_word : page_q;
    assign pw_d    = fire ? PW_LOAD : ((pw_q != '0) ? pw_q - 1'b1 : '0);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_OFF;
            per_q   <= '0;
        end else begin
            state_q <= state_d;
            per_q   <= per_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            slot_q  <= '0;
            bit_q   <= '0;
            burst_q <= 1'b0;
            page_q  <= '0;
        end else begin
            slot_q  <= slot_d;
            bit_q   <= bit_d;
            burst_q <= burst_d;
            page_q  <= page_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pw_q    <= '0;
            pulse_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            pw_q    <= pw_d;
            pulse_q <= pw_d != '0;
            done_q  <= last_clk;
        end
    end

    signal_detect_qualifier #(
        .ON_CYC  (DETECT_ON),
        .OFF_CYC (DETECT_OFF)
    ) u_detect (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_raw     (i_rx_energy),
        .o_present (o_signal_present_detect)
    );

    assign o_link_pulse   = pulse_q;
    assign o_burst_active = burst_q;
    assign o_burst_done   = done_q;

    // checking helpers, read only by the properties below
    logic [7:0]       hi_len_q;
    logic [CNT_W-1:0] gap_q;
    logic [CNT_W-1:0] clk_gap_q;
    logic [CNT_W-1:0] blen_q;
    logic [5:0]       npulse_q;
    logic             seen_q;
    logic             clk_seen_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hi_len_q   <= '0;
            gap_q      <= '0;
            seen_q     <= 1'b0;
        end else begin
            hi_len_q   <= pulse_q ? hi_len_q + 1'b1 : '0;
            gap_q      <= (idle_fire || burst_start) ? CNT_W'(1) : gap_q + 1'b1;
            seen_q     <= (seen_q || idle_fire || burst_start) && active;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clk_gap_q  <= '0;
            blen_q     <= '0;
            npulse_q   <= '0;
            clk_seen_q <= 1'b0;
        end else begin
            clk_gap_q  <= clk_fire ? CNT_W'(1) : clk_gap_q + 1'b1;
            blen_q     <= burst_start ? '0 : blen_q + 1'b1;
            npulse_q   <= burst_start ? '0 : npulse_q + 6'((clk_fire || data_fire) ? 1 : 0);
            clk_seen_q <= burst_q && !last_clk;
        end
    end

    pulse_width_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $fell(pulse_q) |-> $past(hi_len_q) == PW_LOAD - 8'h01)
        else $error("link pulse width wrong");

    idle_spacing_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (idle_fire && seen_q && $past(state_q) == ST_IDLE) |->
            gap_q >= CNT_W'(IDLE_LO) && gap_q <= CNT_W'(IDLE_HI))
        else $error("idle pulse spacing out of range");

    clk_interval_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (clk_fire && clk_seen_q) |->
            clk_gap_q >= CNT_W'(SLOT_LO) && clk_gap_q <= CNT_W'(SLOT_HI))
        else $error("clock pulse interval out of range");

    data_offset_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        data_fire |->
            clk_gap_q >= CNT_W'(DATA_LO) && clk_gap_q <= CNT_W'(DATA_HI))
        else $error("data pulse offset out of range");

    zero_slot_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (burst_q && slot_q == DATA_AT && !bit_one) |-> ##1 !pulse_q)
        else $error("pulse sent for a zero bit");

    burst_count_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $rose(done_q) |->
            npulse_q >= 6'(BURST_PULSES_MIN) && npulse_q <= 6'(BURST_PULSES_MAX))
        else $error("pulse count in burst out of range");

    // blen_q reads zero on the first clock pulse, so the span is bits times interval
    burst_width_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        last_clk |-> blen_q == CNT_W'(PAGE_BITS * INTERVAL_CYC))
        else $error("burst width wrong");

    burst_period_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (burst_start && seen_q && $past(state_q) == ST_NEG) |->
            gap_q >= CNT_W'(BURST_LO) && gap_q <= CNT_W'(BURST_HI))
        else $error("burst to burst period out of range");

endmodule

// [dv/link_partner_model.sv]
`timescale 1ns/100ps
module link_partner_model #(
    parameter int WIDTH_CYC = 10
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_line,
    input  wire logic i_energy_on,
    input  wire logic i_clear,
    output logic      o_rx_energy,
    output logic      o_bad_width
);
    int run_q;
    // far transmitter energy seen as a plain level, no analog threshold modelled
    assign o_rx_energy = i_energy_on;
    // width is judged on the falling edge only, so a pulse cut by abort shows up too
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            run_q       <= 0;
            o_bad_width <= 1'b0;
        end else begin
            run_q <= i_line ? run_q + 1 : 0;
            if (i_clear) begin
                o_bad_width <= 1'b0;
            end else if (!i_line && run_q != 0 && run_q != WIDTH_CYC) begin
                o_bad_width <= 1'b1;
            end
        end
    end
endmodule

// [dv/link_pulse_timing_generator_tb_top.sv]
`timescale 1ns/100ps
module link_pulse_timing_generator_tb_top;
    import link_pulse_pkg::*;
    // short counts keep the run small; timing expectations derive from these, pulse width from PULSE_WIDTH_CYC
    localparam int IDLE_C  = 400;
    localparam int BURST_C = 400;
    localparam int INT_C   = 24;
    localparam int DATA_C  = 12;
    localparam int ON_C    = 20;
    localparam int OFF_C   = 10;
    logic        i_clk        = 1'b0;
    logic        i_resetn     = 1'b0;
    logic        i_autoneg_en = 1'b0;
    logic        i_link_idle  = 1'b0;
    logic [15:0] i_page_word  = 16'h0000;
    logic        carrier_on   = 1'b0;
    logic        clr_width    = 1'b0;
    logic        pulse_prev   = 1'b0;
    logic        done_seen    = 1'b0;
    logic        i_rx_energy;
    logic        o_link_pulse;
    logic        o_burst_active;
    logic        o_burst_done;
    logic        o_signal_present_detect;
    logic        bad_width;
    int          fails        = 0;
    int          n_compared   = 0;
    int          cyc          = 0;
    int          starts[$];

    link_pulse_timing_generator #(.IDLE_CYC(IDLE_C), .BURST_CYC(BURST_C), .INTERVAL_CYC(INT_C),
        .DATA_CYC(DATA_C), .DETECT_ON(ON_C), .DETECT_OFF(OFF_C)) u_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_autoneg_en(i_autoneg_en),
        .i_link_idle(i_link_idle), .i_page_word(i_page_word), .i_rx_energy(i_rx_energy),
        .o_link_pulse(o_link_pulse), .o_burst_active(o_burst_active),
        .o_burst_done(o_burst_done), .o_signal_present_detect(o_signal_present_detect));

    link_partner_model #(.WIDTH_CYC(PULSE_WIDTH_CYC)) u_partner (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_line(o_link_pulse), .i_energy_on(carrier_on),
        .i_clear(clr_width), .o_rx_energy(i_rx_energy), .o_bad_width(bad_width));

    always #5 i_clk = ~i_clk;

    // pulse start times in cycles, taken from pre-edge values
    always @(posedge i_clk) begin
        cyc        <= cyc + 1;
        pulse_prev <= o_link_pulse;
        if (o_link_pulse === 1'b1 && pulse_prev !== 1'b1) starts.push_back(cyc);
        if (o_burst_done === 1'b1) done_seen <= 1'b1;
    end

    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_starts(input int n, input int limit);
        for (int k = 0; k < limit && starts.size() < n; k++) @(posedge i_clk);
        if (starts.size() < n) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic fresh;
        @(posedge i_clk);
        clr_width <= 1'b1;
        @(negedge i_clk);
        starts.delete();
        done_seen = 1'b0;
        @(posedge i_clk);
        clr_width <= 1'b0;
    endtask

    task automatic idle_pulses;
        fresh();
        i_link_idle <= 1'b1;
        wait_starts(3, 3 * IDLE_C);
        check("idle gap", IDLE_C, starts[2] - starts[1]);
        repeat (PULSE_WIDTH_CYC + 2) @(posedge i_clk);
        check("idle width", 0, bad_width);
        i_link_idle <= 1'b0;
    endtask

    // one burst checked pulse by pulse, then the next start, then an abort
    task automatic burst(input logic [15:0] word, input logic idle_too);
        int exp[$];
        for (int k = 0; k < 17; k++) begin
            exp.push_back(k * INT_C);
            if (k < 16 && word[k]) exp.push_back(k * INT_C + DATA_C);
        end
        fresh();
        i_page_word  <= word;
        i_autoneg_en <= 1'b1;
        i_link_idle  <= idle_too;
        for (int k = 0; k < 20 * INT_C && !done_seen; k++) @(posedge i_clk);
        check("burst done", 1, done_seen);
        check("pulse count", exp.size(), starts.size());
        for (int i = 0; i < exp.size() && i < starts.size(); i++) begin
            check("pulse offset", exp[i], starts[i] - starts[0]);
        end
        check("burst width", 0, bad_width);
        wait_starts(exp.size() + 1, 2 * BURST_C);
        check("burst period", BURST_C, starts[exp.size()] - starts[0]);
        // forget the first burst's done so the abort check sees only the cut one
        done_seen = 1'b0;
        repeat (INT_C) @(posedge i_clk);
        check("burst active", 1, o_burst_active);
        i_autoneg_en <= 1'b0;
        i_link_idle  <= 1'b0;
        repeat (3) @(negedge i_clk);
        check("abort active", 0, o_burst_active);
        repeat (18 * INT_C) @(posedge i_clk);
        check("abort done", 0, done_seen);
    endtask

    task automatic detect;
        int k;
        @(posedge i_clk);
        carrier_on <= 1'b1;
        repeat (ON_C - 5) @(posedge i_clk);
        carrier_on <= 1'b0;
        repeat (ON_C + 5) @(posedge i_clk);
        check("detect glitch", 0, o_signal_present_detect);
        carrier_on <= 1'b1;
        for (k = 0; k < ON_C + 10 && o_signal_present_detect !== 1'b1; k++) @(posedge i_clk);
        check("detect on", 1, k >= ON_C - 1 && k <= ON_C + 2);
        carrier_on <= 1'b0;
        for (k = 0; k < OFF_C + 10 && o_signal_present_detect !== 1'b0; k++) @(posedge i_clk);
        check("detect off", 1, k >= OFF_C - 1 && k <= OFF_C + 2);
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        check("reset outputs", 0, {o_link_pulse, o_burst_active, o_burst_done,
                                   o_signal_present_detect});
        i_resetn <= 1'b1;
        idle_pulses();
        burst(16'h0000, 1'b0);
        burst(16'hffff, 1'b1);
        burst(16'ha5c3, 1'b0);
        detect();
        end_of_test();
    end
endmodule
